/* File: inc/cmad_pkg.sv */
package cmad_pkg;

  // ---------------------------------------------------------------
  // internal data space
  // ---------------------------------------------------------------
  localparam int unsigned IRAM_BYTES = 256;
  localparam logic [7:0] IRAM_UPPER_BASE = 8'h80;
  localparam logic [7:0] BANK_AREA_END = 8'h1F;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_AREA_END = 8'h2F;
  localparam logic [7:0] BIT_BYTE_SEL = 8'h80;
  localparam int unsigned BANK_SHIFT = 3;

  // ---------------------------------------------------------------
  // external data space
  // ---------------------------------------------------------------
  localparam int unsigned XRAM_BYTES = 4096;
  localparam int unsigned XRAM_AW = 12;
  localparam logic [15:0] XRAM_LIMIT = 16'h1000;

  // ---------------------------------------------------------------
  // program space
  // ---------------------------------------------------------------
  localparam logic [16:0] FLASH_RSV_BASE = 17'h0FE00;
  localparam logic [16:0] FLASH_RSV_END = 17'h0FFFF;
  localparam logic [16:0] FLASH_EXTRA_BASE = 17'h10000;
  localparam logic [16:0] FLASH_EXTRA_END = 17'h1007F;
  localparam int unsigned SECTOR_SHIFT = 9;

  typedef enum logic [1:0] {
    XMAP_ONCHIP = 2'b00,
    XMAP_SPLIT = 2'b01,
    XMAP_OFFCHIP = 2'b10
  } cmad_xmap_t;

  typedef enum logic [1:0] {
    DST_NONE = 2'b00,
    DST_IRAM = 2'b01,
    DST_PERIPH = 2'b10
  } cmad_idst_t;

  // internal data access request
  typedef struct packed {
    logic valid;
    logic indirect;
    logic bit_op;
    logic reg_op;
    logic [7:0] addr;
  } cmad_ireq_t;

  // routed internal data access
  typedef struct packed {
    cmad_idst_t dest;
    logic [7:0] addr;
    logic [2:0] bit_idx;
    logic bit_op;
  } cmad_iroute_t;

  // external data route
  typedef struct packed {
    logic onchip;
    logic offchip;
    logic [15:0] addr;
  } cmad_xroute_t;

  // program fetch route
  typedef struct packed {
    logic valid;
    logic reserved;
    logic extra;
    logic [6:0] sector;
    logic [16:0] addr;
  } cmad_froute_t;

endpackage

/* File: hw/cmad_offchip_port.sv */
`timescale 1ns/1ns
module cmad_offchip_port
  import cmad_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_mux_mode,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_ale,
  output logic [7:0] o_ad_out,
  output logic o_ad_oe,
  output logic [7:0] o_addr_hi,
  output logic [7:0] o_addr_lo,
  output logic [7:0] o_data_out,
  output logic o_data_oe
);

  // ---------------------------------------------------------------
  // shared or separate address and data lines
  // ---------------------------------------------------------------
  logic next_ale;
  logic [7:0] next_ad_out;
  logic next_ad_oe;
  logic [7:0] next_addr_hi;
  logic [7:0] next_addr_lo;
  logic [7:0] next_data_out;
  logic next_data_oe;
  logic wr_pend;
  logic [7:0] wr_hold;
  logic next_wr_pend;
  logic [7:0] next_wr_hold;

  // multiplexed writes take two cycles: address with ale, then data;
  // a new request in the data phase takes the lines, so callers leave
  // one idle cycle after a multiplexed write
  always_comb
  begin
    next_ale = 1'b0;
    next_ad_out = 8'h00;
    next_ad_oe = 1'b0;
    next_addr_hi = o_addr_hi;
    next_addr_lo = o_addr_lo;
    next_data_out = 8'h00;
    next_data_oe = 1'b0;
    next_wr_pend = 1'b0;
    next_wr_hold = wr_hold;
    if (wr_pend)
    begin
      next_ad_out = wr_hold;
      next_ad_oe = 1'b1;
    end
    if (i_req)
    begin
      next_addr_hi = i_addr[15:8];
      if (i_mux_mode)
      begin
        next_ale = 1'b1;
        next_ad_out = i_addr[7:0];
        next_ad_oe = 1'b1;
        next_wr_pend = i_we;
        next_wr_hold = i_wdata;
      end
      else
      begin
        next_addr_lo = i_addr[7:0];
        next_data_out = i_wdata;
        next_data_oe = i_we;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_ale <= 1'b0;
      o_ad_out <= 8'h00;
      o_ad_oe <= 1'b0;
      o_addr_hi <= 8'h00;
      o_addr_lo <= 8'h00;
      o_data_out <= 8'h00;
      o_data_oe <= 1'b0;
      wr_pend <= 1'b0;
      wr_hold <= 8'h00;
    end
    else
    begin
      wr_pend <= next_wr_pend;
      wr_hold <= next_wr_hold;
      o_ale <= next_ale;
      o_ad_out <= next_ad_out;
      o_ad_oe <= next_ad_oe;
      o_addr_hi <= next_addr_hi;
      o_addr_lo <= next_addr_lo;
      o_data_out <= next_data_out;
      o_data_oe <= next_data_oe;
    end
  end

  a_mux_ale: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req && i_mux_mode |=> o_ale && o_ad_oe)
    else $error("multiplexed access without address latch");
  a_sep_lines: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req && !i_mux_mode |=> !o_ale && o_addr_lo == $past(i_addr[7:0]))
    else $error("separate mode lines wrong");

  sequence s_mux_write;
    i_req && i_mux_mode && i_we ##1 !i_req;
  endsequence

  a_mux_data: assert property (@(posedge i_clk) disable iff (i_srst)
    s_mux_write |=> !o_ale && o_ad_oe && o_ad_out == $past(i_wdata, 2))
    else $error("multiplexed write data phase wrong");

endmodule // cmad_offchip_port

/* File: hw/cmad_decoder.sv */
`timescale 1ns/1ns
module cmad_decoder
  import cmad_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire cmad_ireq_t i_ireq,
  input wire logic [1:0] i_bank_sel,
  input wire logic i_iwe,
  input wire logic [7:0] i_iwdata,
  input wire logic i_ibit_wval,
  output logic [7:0] o_irdata,
  output logic o_irbit,
  output cmad_iroute_t o_iroute,
  input wire logic i_xreq,
  input wire logic i_xwe,
  input wire logic [15:0] i_xaddr,
  input wire logic [7:0] i_xwdata,
  input wire logic [1:0] i_xmap,
  input wire logic i_mux_mode,
  output logic [7:0] o_xrdata,
  output cmad_xroute_t o_xroute,
  output logic o_ale,
  output logic [7:0] o_ad_out,
  output logic o_ad_oe,
  output logic [7:0] o_addr_hi,
  output logic [7:0] o_addr_lo,
  output logic [7:0] o_data_out,
  output logic o_data_oe,
  input wire logic i_freq,
  input wire logic [16:0] i_faddr,
  output cmad_froute_t o_froute
);

  // ---------------------------------------------------------------
  // internal data decode
  // ---------------------------------------------------------------
  logic [7:0] iram [IRAM_BYTES];
  logic [7:0] eff_addr;
  cmad_idst_t dst;
  logic [7:0] bit_byte;
  logic [2:0] bit_idx;

  always_comb
  begin
    eff_addr = i_ireq.addr;
    bit_byte = i_ireq.addr;
    bit_idx = 3'h0;
    if (i_ireq.reg_op)
      eff_addr = {3'h0, i_bank_sel, i_ireq.addr[2:0]};
    if (i_ireq.bit_op)
    begin
      // bit address below 0x80 selects a bit in the bit area
      bit_byte = BIT_AREA_BASE + {4'h0, i_ireq.addr[6:3]};
      bit_idx = i_ireq.addr[2:0];
      eff_addr = (i_ireq.addr < BIT_BYTE_SEL) ? bit_byte
               : {i_ireq.addr[7:3], 3'h0};
    end
    if (!i_ireq.valid)
      dst = DST_NONE;
    else if (eff_addr < IRAM_UPPER_BASE)
      dst = DST_IRAM;
    else if (i_ireq.indirect)
      dst = DST_IRAM;
    else
      dst = DST_PERIPH;
  end

  cmad_iroute_t next_iroute;
  logic [7:0] next_irdata;
  logic next_irbit;
  logic [7:0] ram_wbyte;

  always_comb
  begin
    next_iroute.dest = dst;
    next_iroute.addr = eff_addr;
    next_iroute.bit_idx = bit_idx;
    next_iroute.bit_op = i_ireq.bit_op;
    next_irdata = (dst == DST_IRAM) ? iram[eff_addr] : 8'h00;
    next_irbit = next_irdata[bit_idx];
    ram_wbyte = iram[eff_addr];
    if (i_ireq.bit_op)
      ram_wbyte[bit_idx] = i_ibit_wval;
    else
      ram_wbyte = i_iwdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (dst == DST_IRAM && i_iwe)
      iram[eff_addr] <= ram_wbyte;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_iroute <= '0;
      o_irdata <= 8'h00;
      o_irbit <= 1'b0;
    end
    else
    begin
      o_iroute <= next_iroute;
      o_irdata <= next_irdata;
      o_irbit <= next_irbit;
    end
  end

  // ---------------------------------------------------------------
  // external data decode
  // ---------------------------------------------------------------
  logic [7:0] xram [XRAM_BYTES];
  logic x_on;
  logic x_off;
  logic [XRAM_AW-1:0] x_idx;

  always_comb
  begin
    x_idx = i_xaddr[XRAM_AW-1:0];
    x_on = 1'b0;
    x_off = 1'b0;
    if (i_xreq)
    begin
      case (cmad_xmap_t'(i_xmap))
        XMAP_ONCHIP: x_on = 1'b1;
        XMAP_SPLIT:
        begin
          x_on = (i_xaddr < XRAM_LIMIT);
          x_off = !x_on;
        end
        XMAP_OFFCHIP: x_off = 1'b1;
        default: x_on = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (x_on && i_xwe)
      xram[x_idx] <= i_xwdata;
  end

  cmad_xroute_t next_xroute;
  logic [7:0] next_xrdata;

  always_comb
  begin
    next_xroute.onchip = x_on;
    next_xroute.offchip = x_off;
    next_xroute.addr = i_xaddr;
    next_xrdata = x_on ? xram[x_idx] : 8'h00;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_xroute <= '0;
      o_xrdata <= 8'h00;
    end
    else
    begin
      o_xroute <= next_xroute;
      o_xrdata <= next_xrdata;
    end
  end

  cmad_offchip_port u_offchip_data_port (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_mux_mode(i_mux_mode),
    .i_req(x_off),
    .i_we(i_xwe),
    .i_addr(i_xaddr),
    .i_wdata(i_xwdata),
    .o_ale(o_ale),
    .o_ad_out(o_ad_out),
    .o_ad_oe(o_ad_oe),
    .o_addr_hi(o_addr_hi),
    .o_addr_lo(o_addr_lo),
    .o_data_out(o_data_out),
    .o_data_oe(o_data_oe)
  );

  // ---------------------------------------------------------------
  // program flash decode
  // ---------------------------------------------------------------
  cmad_froute_t next_froute;

  always_comb
  begin
    next_froute.addr = i_faddr;
    next_froute.sector = 7'(i_faddr >> SECTOR_SHIFT);
    next_froute.reserved = i_freq && i_faddr >= FLASH_RSV_BASE
                         && i_faddr <= FLASH_RSV_END;
    next_froute.extra = i_freq && i_faddr >= FLASH_EXTRA_BASE
                      && i_faddr <= FLASH_EXTRA_END;
    next_froute.valid = i_freq && !next_froute.reserved
                      && (i_faddr < FLASH_RSV_BASE
                          || next_froute.extra);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_froute <= '0;
    else
      o_froute <= next_froute;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_direct_upper;
    i_ireq.valid && !i_ireq.indirect && !i_ireq.reg_op
      && !i_ireq.bit_op && i_ireq.addr[7];
  endsequence

  sequence s_indirect_upper;
    i_ireq.valid && i_ireq.indirect && !i_ireq.reg_op
      && !i_ireq.bit_op && i_ireq.addr[7];
  endsequence

  a_upper_indirect: assert property (@(posedge i_clk) disable iff (i_srst)
    s_indirect_upper |=> o_iroute.dest == DST_IRAM)
    else $error("indirect upper access not in ram");
  a_upper_direct: assert property (@(posedge i_clk) disable iff (i_srst)
    s_direct_upper |=> o_iroute.dest == DST_PERIPH)
    else $error("direct upper access not to peripherals");
  a_lower_same: assert property (@(posedge i_clk) disable iff (i_srst)
    i_ireq.valid && !i_ireq.addr[7] && !i_ireq.bit_op && !i_ireq.reg_op
    |=> o_iroute.dest == DST_IRAM && o_iroute.addr == $past(i_ireq.addr))
    else $error("lower access misrouted");
  a_bank_offset: assert property (@(posedge i_clk) disable iff (i_srst)
    i_ireq.valid && i_ireq.reg_op && !i_ireq.bit_op
    |=> o_iroute.addr == {3'h0, $past(i_bank_sel), $past(i_ireq.addr[2:0])})
    else $error("register bank offset wrong");
  a_bit_area: assert property (@(posedge i_clk) disable iff (i_srst)
    i_ireq.valid && i_ireq.bit_op && !i_ireq.addr[7]
    |=> o_iroute.addr >= BIT_AREA_BASE && o_iroute.addr <= BIT_AREA_END)
    else $error("bit access outside bit area");
  a_xmap_alias: assert property (@(posedge i_clk) disable iff (i_srst)
    i_xreq && i_xmap == XMAP_ONCHIP |=> o_xroute.onchip && !o_xroute.offchip)
    else $error("on-chip mode did not alias");
  a_xmap_split: assert property (@(posedge i_clk) disable iff (i_srst)
    i_xreq && i_xmap == XMAP_SPLIT
    |=> o_xroute.onchip == ($past(i_xaddr) < XRAM_LIMIT))
    else $error("split mode boundary wrong");
  a_flash_rsv: assert property (@(posedge i_clk) disable iff (i_srst)
    i_freq && i_faddr >= FLASH_RSV_BASE && i_faddr <= FLASH_RSV_END
    |=> !o_froute.valid && o_froute.reserved)
    else $error("reserved flash offered");
  a_flash_extra: assert property (@(posedge i_clk) disable iff (i_srst)
    i_freq && i_faddr >= FLASH_EXTRA_BASE && i_faddr <= FLASH_EXTRA_END
    |=> o_froute.valid && o_froute.extra)
    else $error("extra sector not decoded");

endmodule // cmad_decoder

/* File: dv/cmad_xmem_model.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// off-chip data memory on the external port
// ---------------------------------------------------------------
module cmad_xmem_model
(
  input wire logic i_clk,
  input wire logic i_mux_mode,
  input wire logic i_ale,
  input wire logic [7:0] i_ad_out,
  input wire logic i_ad_oe,
  input wire logic [7:0] i_addr_hi,
  input wire logic [7:0] i_addr_lo,
  input wire logic [7:0] i_data_out,
  input wire logic i_data_oe,
  input wire logic [15:0] i_look,
  output logic [7:0] o_look
);
  logic [7:0] mem [logic [15:0]];
  logic [15:0] mux_addr;

  assign o_look = mem.exists(i_look) ? mem[i_look] : 8'h00;

  // shared lines: address latched with ale, data in a later cycle
  always @(posedge i_clk)
  begin
    if (i_mux_mode && i_ale)
    begin
      mux_addr <= {i_addr_hi, i_ad_out};
    end
    else if (i_mux_mode && i_ad_oe)
    begin
      mem[mux_addr] = i_ad_out;
    end
    else if (!i_mux_mode && i_data_oe)
    begin
      mem[{i_addr_hi, i_addr_lo}] = i_data_out;
    end
  end
endmodule // cmad_xmem_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top
  import cmad_pkg::*;
;
  logic i_clk, i_srst, i_iwe, i_ibit_wval, i_xreq, i_xwe, i_mux_mode;
  logic i_freq, o_irbit, o_ale, o_ad_oe, o_data_oe;
  cmad_ireq_t i_ireq;
  cmad_iroute_t o_iroute;
  cmad_xroute_t o_xroute;
  cmad_froute_t o_froute;
  logic [1:0] i_bank_sel, i_xmap;
  logic [7:0] i_iwdata, i_xwdata, o_irdata, o_xrdata, o_ad_out;
  logic [7:0] o_addr_hi, o_addr_lo, o_data_out, look_data;
  logic [15:0] i_xaddr, look_addr;
  logic [16:0] i_faddr;
  int fail_count, check_count;

  cmad_decoder dut (.i_clk(i_clk), .i_srst(i_srst), .i_ireq(i_ireq),
    .i_bank_sel(i_bank_sel), .i_iwe(i_iwe), .i_iwdata(i_iwdata),
    .i_ibit_wval(i_ibit_wval), .o_irdata(o_irdata), .o_irbit(o_irbit),
    .o_iroute(o_iroute), .i_xreq(i_xreq), .i_xwe(i_xwe),
    .i_xaddr(i_xaddr), .i_xwdata(i_xwdata), .i_xmap(i_xmap),
    .i_mux_mode(i_mux_mode), .o_xrdata(o_xrdata), .o_xroute(o_xroute),
    .o_ale(o_ale), .o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe),
    .o_addr_hi(o_addr_hi), .o_addr_lo(o_addr_lo),
    .o_data_out(o_data_out), .o_data_oe(o_data_oe), .i_freq(i_freq),
    .i_faddr(i_faddr), .o_froute(o_froute));

  cmad_xmem_model xmem (.i_clk(i_clk), .i_mux_mode(i_mux_mode),
    .i_ale(o_ale), .i_ad_out(o_ad_out), .i_ad_oe(o_ad_oe),
    .i_addr_hi(o_addr_hi), .i_addr_lo(o_addr_lo),
    .i_data_out(o_data_out), .i_data_oe(o_data_oe),
    .i_look(look_addr), .o_look(look_data));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // outputs of the request are settled at the following falling edge
  task automatic iacc(input logic ind, input logic bo, input logic ro,
    input logic we, input logic [7:0] a, input logic [7:0] wd,
    input logic bv);
    @(negedge i_clk);
    i_ireq = {1'b1, ind, bo, ro, a};
    i_iwe = we;
    i_iwdata = wd;
    i_ibit_wval = bv;
    @(negedge i_clk);
    i_ireq.valid = 1'b0;
    i_iwe = 1'b0;
  endtask

  task automatic xacc(input logic [1:0] m, input logic mx, input logic we,
    input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_xmap = m;
    i_mux_mode = mx;
    i_xreq = 1'b1;
    i_xwe = we;
    i_xaddr = a;
    i_xwdata = d;
    @(negedge i_clk);
    i_xreq = 1'b0;
    i_xwe = 1'b0;
  endtask

  task automatic fetch(input logic [16:0] a, input logic v,
    input logic r, input logic x);
    @(negedge i_clk);
    i_freq = 1'b1;
    i_faddr = a;
    @(negedge i_clk);
    i_freq = 1'b0;
    chk({o_froute.valid, o_froute.reserved, o_froute.extra},
        {v, r, x});
  endtask

  task automatic xrt(input logic [1:0] m, input logic [15:0] a,
    input logic on, input logic off);
    xacc(m, 1'b0, 1'b0, a, 8'h00);
    chk({o_xroute.onchip, o_xroute.offchip}, {on, off});
    chk(o_xroute.addr, a);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk(o_iroute, 32'h0);
    chk(o_xroute, 32'h0);
    chk(o_froute, 32'h0);
    chk(o_froute.addr, 17'h0);
  endtask

  task automatic t_dual_map;
    iacc(1, 0, 0, 1, 8'h90, 8'hA5, 0);
    iacc(0, 0, 0, 0, 8'h90, 8'h00, 0);
    chk(o_iroute.dest, DST_PERIPH);
    chk(o_irdata, 8'h00);
    iacc(1, 0, 0, 0, 8'h90, 8'h00, 0);
    chk(o_iroute.dest, DST_IRAM);
    chk(o_irdata, 8'hA5);
    iacc(0, 0, 0, 1, 8'h7F, 8'h5C, 0);
    iacc(1, 0, 0, 0, 8'h7F, 8'h00, 0);
    chk(o_irdata, 8'h5C);
  endtask

  task automatic t_banks;
    for (int b = 0; b < 4; b++)
    begin
      i_bank_sel = b[1:0];
      iacc(0, 0, 1, 1, 8'h03, 8'h40 + 8'(b), 0);
      iacc(1, 0, 0, 0, 8'(b * 8 + 3), 8'h00, 0);
      chk(o_irdata, 8'h40 + 8'(b));
      chk(o_iroute.dest, DST_IRAM);
    end
  endtask

  task automatic t_bits;
    iacc(0, 0, 0, 1, 8'h25, 8'h00, 0);
    iacc(0, 1, 0, 1, 8'h2B, 8'h00, 1);
    iacc(0, 0, 0, 0, 8'h25, 8'h00, 0);
    chk(o_irdata, 8'h08);
    iacc(0, 1, 0, 0, 8'h2B, 8'h00, 0);
    chk({o_irbit, o_iroute.addr, o_iroute.bit_idx}, {1'b1, 8'h25, 3'h3});
    iacc(0, 1, 0, 0, 8'h89, 8'h00, 0);
    chk({o_iroute.dest, o_iroute.addr, o_iroute.bit_idx},
        {DST_PERIPH, 8'h88, 3'h1});
  endtask

  task automatic t_xdata;
    xacc(2'h0, 0, 1, 16'h0123, 8'h5A);
    xacc(2'h0, 0, 0, 16'h7123, 8'h00);
    chk(o_xrdata, 8'h5A);
    xrt(2'h0, 16'hF123, 1, 0);
    xrt(2'h1, 16'h0FFF, 1, 0);
    xrt(2'h1, 16'h1000, 0, 1);
    xrt(2'h2, 16'h0010, 0, 1);
    xrt(2'h3, 16'h2000, 1, 0);
    xacc(2'h2, 1, 1, 16'h3456, 8'hC3);
    chk({o_ale, o_ad_oe, o_ad_out, o_addr_hi}, {2'b11, 16'h5634});
    @(negedge i_clk);
    chk({o_ale, o_ad_oe, o_ad_out}, {2'b01, 8'hC3});
    xacc(2'h1, 0, 1, 16'h2F10, 8'h3C);
    chk({o_data_oe, o_ad_oe, o_data_out}, {2'b10, 8'h3C});
    chk({o_addr_hi, o_addr_lo}, 16'h2F10);
    @(negedge i_clk);
    look_addr = 16'h3456;
    #1 chk(look_data, 8'hC3);
    look_addr = 16'h2F10;
    #1 chk(look_data, 8'h3C);
    xacc(2'h2, 0, 0, 16'h3456, 8'h00);
    chk(o_xrdata, 8'h00);
  endtask

  task automatic t_flash;
    fetch(17'h0FDFF, 1, 0, 0);
    chk(o_froute.sector, 7'h7E);
    fetch(17'h0FE00, 0, 1, 0);
    fetch(17'h0FFFF, 0, 1, 0);
    fetch(17'h10000, 1, 0, 1);
    fetch(17'h1007F, 1, 0, 1);
  endtask

  // ---------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ---------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial
  begin
    fail_count = 0;
    check_count = 0;
    i_srst = 1'b1;
    i_ireq = '0;
    {i_iwe, i_ibit_wval, i_xreq, i_xwe, i_mux_mode, i_freq} = '0;
    {i_bank_sel, i_xmap, i_iwdata, i_xwdata} = '0;
    i_xaddr = '0;
    i_faddr = '0;
    look_addr = '0;
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    t_reset();
    t_dual_map();
    t_banks();
    t_bits();
    t_xdata();
    t_flash();
    results();
  end

  initial
  begin
    #200000;
    fail_count++;
    results();
  end
endmodule // tb_top
